//--- core/dvmc_measurement_control.sv
// Measurement control of an integrating voltmeter: command registers,
// trigger and reading sequencing, zero correction and reading storage.
// Assumes a classic Wishbone master and a converter on the same clock.
`include "dvmc_map.svh"
`default_nettype none
// How it works
// R1: Power-up, panel reset, device clear restore defaults.
// R2: Defaults: autozero, no current, 5.5 digits.
// R3: Autozero: zero then input, report difference.
// R4: No autozero: zero once per range change.
// R5: Current source codes 0..3, off to 1 mA.
// R6: Resolution 3/4/5 sets 0.01/0.1/1 PLC.
// R7: Display 4/5/6 digits, 3.5 limits lead.
// R8: Integration fixed by resolution, plus run-down.
// R9: Reading rate capped per table, 50 Hz scaled.
// R10: Readings per trigger from 1 to 999.
// R11: Trigger mode selects one of four.
// R12: Range fixed or automatic.
// R13: Storage holds readings for later transfer.
// R14: Programmable wait between successive readings.
// R15: Output format picks one of three.
// R16: Format codes 1 ASCII, 2 BCD, 3 time.
// R17: Completion emits a 0.5 us pulse.
// R18: Illegal parameters ignored, setting kept.
module dvmc_measurement_control #(
    parameter int CLK_HZ    = 10_000_000, // Clock rate in hertz.
    parameter int DATA_W    = 24,         // Converter result width.
    parameter int STORE_DEP = 100         // Stored readings.
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                panelReset,
    input  wire logic                busDeviceClear,
    input  wire logic                extTrigger,
    input  wire logic                lineIs50Hz,
    output logic                     convStart,
    output logic                     convZeroPhase,
    output logic      [23:0]         convIntegCycles,
    input  wire logic                convDone,
    input  wire logic [DATA_W-1:0]   convData,
    output dvmc_pkg::dvmc_cfg_t      cfgOut,
    output logic      [2:0]          digitCount,
    output logic                     leadDigitLimited,
    output logic                     measurement_done_output
);
    import dvmc_pkg::*;

    // --------
    // Derived timing
    // --------
    // Completion pulse, rounded down, never below one cycle.
    localparam int DONE_CYC_RAW = (CLK_HZ / 1_000_000) *
                                  `DVMC_DONE_PULSE_NS / 1000;
    localparam int DONE_CYC = (DONE_CYC_RAW < 1) ? 1 : DONE_CYC_RAW;
    // One wait step in cycles.
    localparam int WAIT_TICK_CYC = (CLK_HZ / 1_000_000) * `DVMC_WAIT_TICK_US;

    // Integration length in cycles from resolution and line rate.
    function automatic logic [23:0] integCyc(logic [2:0] res, logic is50);
        int plc;
        int hz;
        plc = (res == 3'h3) ? `DVMC_PLC100_R3 :
              (res == 3'h4) ? `DVMC_PLC100_R4 : `DVMC_PLC100_R5;
        hz  = is50 ? `DVMC_LINE_HZ_50 : `DVMC_LINE_HZ_60;
        return 24'((CLK_HZ / 100) * plc / hz);
    endfunction

    // Least reading period in cycles, rounded up; 50 Hz runs at 5/6.
    function automatic logic [23:0] periodCyc(logic [2:0] res, logic az,
                                              logic is50);
        int rate;
        int num;
        int den;
        if (az) begin
            rate = (res == 3'h3) ? `DVMC_RATE_AZON_R3 :
                   (res == 3'h4) ? `DVMC_RATE_AZON_R4 : `DVMC_RATE_AZON_R5;
        end else begin
            rate = (res == 3'h3) ? `DVMC_RATE_AZOFF_R3 :
                   (res == 3'h4) ? `DVMC_RATE_AZOFF_R4 : `DVMC_RATE_AZOFF_R5;
        end
        num = is50 ? CLK_HZ / 5 * 6 : CLK_HZ;
        den = rate;
        return 24'((num + den - 1) / den);
    endfunction

    // Check a command parameter against its legal limits.
    function automatic logic inRange(logic [31:0] v, logic [31:0] lo,
                                     logic [31:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

    // --------
    // Pin synchronisers
    // --------
    logic [3:0] pinMeta_reg;   // First stage, read only by second stage.
    logic [3:0] pinSync_reg;   // Second stage, safe for logic.
    logic       extPrev_reg;   // Previous synced trigger level.
    logic [3:0] pinMeta_next;
    logic [3:0] pinSync_next;
    logic       extPrev_next;

    // Two flip-flops on each asynchronous pin.
    always_comb begin
        pinMeta_next = {panelReset, busDeviceClear, extTrigger, lineIs50Hz};
        pinSync_next = pinMeta_reg;
        extPrev_next = pinSync_reg[1];
    end

    // Registers the synchronisers.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pinMeta_reg <= 4'h0;
            pinSync_reg <= 4'h0;
            extPrev_reg <= 1'h0;
        end else begin
            pinMeta_reg <= pinMeta_next;
            pinSync_reg <= pinSync_next;
            extPrev_reg <= extPrev_next;
        end
    end

    logic is50;       // Line runs at 50 Hz.
    logic clearReq;   // Restore defaults this cycle.
    logic extEdge;    // Rising edge of the external trigger.
    logic swClear;    // Software clear write.
    assign is50     = pinSync_reg[0];
    assign extEdge  = pinSync_reg[1] & ~extPrev_reg;
    assign clearReq = pinSync_reg[3] | pinSync_reg[2] | swClear; // R1

    // --------
    // Bus slave and configuration
    // --------
    dvmc_cfg_t         cfg_reg;      // Programmed settings.
    dvmc_cfg_t         cfg_next;
    logic              ack_reg;      // Bus answer.
    logic              ack_next;
    logic [31:0]       rdat_reg;     // Read data.
    logic [31:0]       rdat_next;
    logic              swTrig;       // Software trigger write.
    logic              storePop;     // Read of stored reading.
    logic              rangeChg;     // Range or autozero changed.
    logic              wrOk;         // Full-word write this cycle.
    logic              rdOk;         // Read taken this cycle.
    logic [DATA_W-1:0] result_reg;   // Last corrected reading.
    logic [6:0]        rdPtr_reg;    // Oldest stored reading.
    logic [6:0]        storeCnt_reg; // Readings held.
    logic [DATA_W-1:0] storeMem [STORE_DEP];
    dvmc_state_t       state_reg;
    logic              zeroValid_reg;

    assign wrOk = wb_cyc_i & wb_stb_i & ~ack_reg & wb_we_i & (wb_sel_i == 4'hF);
    assign rdOk = wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i;

    // Decodes writes and reads; illegal values leave settings alone.
    always_comb begin
        cfg_next  = cfg_reg;
        ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
        rdat_next = rdat_reg;
        swTrig    = 1'b0;
        swClear   = 1'b0;
        storePop  = 1'b0;
        if (wrOk) begin
            unique case (wb_adr_i)
                `DVMC_OFF_AUTOZERO: if (wb_dat_i <= 32'h1) begin      // R18
                    cfg_next.autozero = wb_dat_i[0];
                end
                `DVMC_OFF_CURSRC: if (wb_dat_i <= `DVMC_MAX_CURSRC) begin
                    cfg_next.curSrc = wb_dat_i[1:0];                // R5
                end
                `DVMC_OFF_RESOL: if (inRange(wb_dat_i, `DVMC_MIN_RESOL,
                                             `DVMC_MAX_RESOL)) begin
                    cfg_next.resol = wb_dat_i[2:0];                 // R6
                end
                `DVMC_OFF_FORMAT: if (inRange(wb_dat_i, `DVMC_MIN_FORMAT,
                                              `DVMC_MAX_FORMAT)) begin
                    cfg_next.format = wb_dat_i[1:0];                // R16
                end
                `DVMC_OFF_RDGCNT: if (inRange(wb_dat_i, `DVMC_MIN_RDGCNT,
                                              `DVMC_MAX_RDGCNT)) begin
                    cfg_next.rdgCnt = wb_dat_i[9:0];                // R10
                end
                `DVMC_OFF_RANGE: if (inRange(wb_dat_i, `DVMC_MIN_RANGE,
                                             `DVMC_MAX_RANGE)) begin
                    cfg_next.range = wb_dat_i[2:0];                 // R12
                end
                `DVMC_OFF_STORAGE: if (wb_dat_i <= `DVMC_MAX_STORAGE) begin
                    cfg_next.storage = wb_dat_i[1:0];               // R13
                end
                `DVMC_OFF_TRIGMODE: if (inRange(wb_dat_i,
                        `DVMC_MIN_TRIGMODE, `DVMC_MAX_TRIGMODE)) begin
                    cfg_next.trigMode = wb_dat_i[2:0];              // R11
                end
                `DVMC_OFF_WAIT: if (wb_dat_i <= `DVMC_MAX_WAIT) begin
                    cfg_next.waitTime = wb_dat_i[19:0];             // R14
                end
                `DVMC_OFF_SWTRIG: swTrig = 1'b1;
                `DVMC_OFF_CLEAR:  swClear = 1'b1;
                default: ;
            endcase
        end
        if (rdOk) begin
            unique case (wb_adr_i)
                `DVMC_OFF_AUTOZERO: rdat_next = 32'(cfg_reg.autozero);
                `DVMC_OFF_CURSRC:   rdat_next = 32'(cfg_reg.curSrc);
                `DVMC_OFF_RESOL:    rdat_next = 32'(cfg_reg.resol);
                `DVMC_OFF_FORMAT:   rdat_next = 32'(cfg_reg.format);
                `DVMC_OFF_RDGCNT:   rdat_next = 32'(cfg_reg.rdgCnt);
                `DVMC_OFF_RANGE:    rdat_next = 32'(cfg_reg.range);
                `DVMC_OFF_STORAGE:  rdat_next = 32'(cfg_reg.storage);
                `DVMC_OFF_TRIGMODE: rdat_next = 32'(cfg_reg.trigMode);
                `DVMC_OFF_WAIT:     rdat_next = 32'(cfg_reg.waitTime);
                `DVMC_OFF_STATUS:   rdat_next = {27'h0, zeroValid_reg,
                                                 1'b0, state_reg};
                `DVMC_OFF_RESULT:   rdat_next = 32'(signed'(result_reg));
                `DVMC_OFF_STORECNT: rdat_next = 32'(storeCnt_reg);
                `DVMC_OFF_STORED: begin
                    rdat_next = 32'(signed'(storeMem[rdPtr_reg]));
                    storePop  = (storeCnt_reg != 7'h0);             // R13
                end
                default: rdat_next = 32'h0;
            endcase
        end
        if (clearReq) begin
            cfg_next = '{`DVMC_RST_AUTOZERO, `DVMC_RST_CURSRC,      // R1
                         `DVMC_RST_RESOL, `DVMC_RST_FORMAT,
                         `DVMC_RST_RDGCNT, `DVMC_RST_RANGE,
                         `DVMC_RST_STORAGE, `DVMC_RST_TRIGMODE,
                         `DVMC_RST_WAIT};
        end
    end

    assign rangeChg = (cfg_next.range != cfg_reg.range) |           // R4
                      (cfg_next.autozero != cfg_reg.autozero);

    // Registers configuration and bus answer; defaults at power-up.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_reg  <= '{`DVMC_RST_AUTOZERO, `DVMC_RST_CURSRC,     // R2
                          `DVMC_RST_RESOL, `DVMC_RST_FORMAT,
                          `DVMC_RST_RDGCNT, `DVMC_RST_RANGE,
                          `DVMC_RST_STORAGE, `DVMC_RST_TRIGMODE,
                          `DVMC_RST_WAIT};
            ack_reg  <= 1'h0;
            rdat_reg <= 32'h0;
        end else begin
            cfg_reg  <= cfg_next;
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // --------
    // Measurement sequencer
    // --------
    dvmc_state_t       state_next;
    logic              zeroValid_next;  // Stored zero still good.
    logic [DATA_W-1:0] zero_reg;        // Zero measurement.
    logic [DATA_W-1:0] zero_next;
    logic [DATA_W-1:0] result_next;
    logic [9:0]        left_reg;        // Readings left in burst.
    logic [9:0]        left_next;
    logic [31:0]       waitCnt_reg;     // Wait between readings.
    logic [31:0]       waitCnt_next;
    logic [23:0]       rateCnt_reg;     // Least reading period.
    logic [23:0]       rateCnt_next;
    logic [7:0]        doneCnt_reg;     // Completion pulse length.
    logic [7:0]        doneCnt_next;
    logic              swPend_reg;      // Software trigger pending.
    logic              swPend_next;
    logic              trigHit;         // Trigger for a new burst.
    logic              storeWr;         // Push a reading.
    logic              startRdg;        // Begin one reading.

    // Computes the trigger, phases, timers and correction.
    always_comb begin
        state_next     = state_reg;
        zeroValid_next = zeroValid_reg & ~rangeChg;                 // R4
        zero_next      = zero_reg;
        result_next    = result_reg;
        left_next      = left_reg;
        waitCnt_next   = (waitCnt_reg != 32'h0) ? waitCnt_reg - 32'h1 : 32'h0;
        rateCnt_next   = (rateCnt_reg != 24'h0) ? rateCnt_reg - 24'h1 : 24'h0;
        doneCnt_next   = (doneCnt_reg != 8'h0) ? doneCnt_reg - 8'h1 : 8'h0;
        swPend_next    = swPend_reg | swTrig;
        storeWr        = 1'b0;
        startRdg       = 1'b0;
        unique case (cfg_reg.trigMode)                              // R11
            3'h1:    trigHit = 1'b1;
            3'h2:    trigHit = extEdge;
            3'h3:    trigHit = swPend_reg;
            default: trigHit = 1'b0;
        endcase
        unique case (state_reg)
            ST_IDLE: if (trigHit) begin
                swPend_next = swTrig;
                left_next   = cfg_reg.rdgCnt;                       // R10
                startRdg    = 1'b1;
            end
            ST_ZERO_GO: state_next = ST_ZERO_WAIT;
            ST_ZERO_WAIT: if (convDone) begin
                zero_next      = convData;
                zeroValid_next = ~cfg_reg.autozero & ~rangeChg;     // R4
                state_next     = ST_IN_GO;
            end
            ST_IN_GO: state_next = ST_IN_WAIT;
            ST_IN_WAIT: if (convDone) begin
                result_next  = DATA_W'(convData - zero_reg);        // R3
                storeWr      = (cfg_reg.storage != 2'h0);           // R13
                doneCnt_next = 8'(DONE_CYC);                        // R17
                left_next    = left_reg - 10'h1;
                waitCnt_next = 32'(cfg_reg.waitTime) * WAIT_TICK_CYC; // R14
                state_next   = ST_GAP;
            end
            ST_GAP: if (waitCnt_reg == 32'h0 && rateCnt_reg == 24'h0) begin
                if (left_reg != 10'h0) begin
                    startRdg = 1'b1;
                end else begin
                    state_next = ST_IDLE;
                end
            end
        endcase
        if (startRdg) begin
            rateCnt_next = periodCyc(cfg_reg.resol, cfg_reg.autozero, is50); // R9
            state_next   = (cfg_reg.autozero | ~zeroValid_next) ?   // R3
                           ST_ZERO_GO : ST_IN_GO;
        end
        if (clearReq) begin
            state_next     = ST_IDLE;
            zeroValid_next = 1'b0;
            swPend_next    = 1'b0;
        end
    end

    // Registers the sequencer and the reading store.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            zeroValid_reg <= 1'h0;
            zero_reg      <= '0;
            result_reg    <= '0;
            left_reg      <= 10'h0;
            waitCnt_reg   <= 32'h0;
            rateCnt_reg   <= 24'h0;
            doneCnt_reg   <= 8'h0;
            swPend_reg    <= 1'h0;
            rdPtr_reg     <= 7'h0;
            storeCnt_reg  <= 7'h0;
        end else begin
            state_reg     <= state_next;
            zeroValid_reg <= zeroValid_next;
            zero_reg      <= zero_next;
            result_reg    <= result_next;
            left_reg      <= left_next;
            waitCnt_reg   <= waitCnt_next;
            rateCnt_reg   <= rateCnt_next;
            doneCnt_reg   <= doneCnt_next;
            swPend_reg    <= swPend_next;
            // Full store drops new readings; a pop frees one slot.
            if (clearReq) begin
                rdPtr_reg    <= 7'h0;
                storeCnt_reg <= 7'h0;
            end else begin
                if (storePop) begin
                    rdPtr_reg <= (rdPtr_reg == 7'(STORE_DEP - 1)) ?
                                 7'h0 : rdPtr_reg + 7'h1;
                end
                storeCnt_reg <= storeCnt_reg
                    + 7'(storeWr && storeCnt_reg != 7'(STORE_DEP))
                    - 7'(storePop);
            end
        end
    end

    // Memory write; the slot follows the newest reading.
    always_ff @(posedge ref_clk) begin
        if (storeWr && storeCnt_reg != 7'(STORE_DEP)) begin
            storeMem[7'((32'(rdPtr_reg) + 32'(storeCnt_reg))
                        % STORE_DEP)] <= result_next;               // R13
        end
    end

    // --------
    // Outputs
    // --------
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign cfgOut = cfg_reg; // R15
    assign convStart = (state_reg == ST_ZERO_GO) |
        (state_reg == ST_IN_GO);
    assign convZeroPhase = (state_reg == ST_ZERO_GO) |
        (state_reg == ST_ZERO_WAIT);
    assign convIntegCycles = integCyc(cfg_reg.resol, is50); // R8
    assign digitCount = cfg_reg.resol + 3'h1; // R7
    assign leadDigitLimited = (cfg_reg.resol == 3'h3); // R7
    assign measurement_done_output = (doneCnt_reg != 8'h0); // R17
endmodule
`default_nettype wire

//--- core/dvmc_map.svh
// Offsets, power-on values, limits and timing of the voltmeter control.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef DVMC_MAP_SVH
`define DVMC_MAP_SVH
// --------
// Register byte offsets
// --------
`define DVMC_OFF_AUTOZERO   8'h00
`define DVMC_OFF_CURSRC     8'h04
`define DVMC_OFF_RESOL      8'h08
`define DVMC_OFF_FORMAT     8'h0C
`define DVMC_OFF_RDGCNT     8'h10
`define DVMC_OFF_RANGE      8'h14
`define DVMC_OFF_STORAGE    8'h18
`define DVMC_OFF_TRIGMODE   8'h1C
`define DVMC_OFF_WAIT       8'h20
`define DVMC_OFF_STATUS     8'h24
`define DVMC_OFF_RESULT     8'h28
`define DVMC_OFF_SWTRIG     8'h2C
`define DVMC_OFF_CLEAR      8'h30
`define DVMC_OFF_STORED     8'h34
`define DVMC_OFF_STORECNT   8'h38
// --------
// Power-on values and legal limits
// --------
`define DVMC_RST_AUTOZERO   1'h1
`define DVMC_RST_CURSRC     2'h0
`define DVMC_RST_RESOL      3'h5
`define DVMC_RST_FORMAT     2'h1
`define DVMC_RST_RDGCNT     10'h001
`define DVMC_RST_RANGE      3'h5
`define DVMC_RST_STORAGE    2'h0
`define DVMC_RST_TRIGMODE   3'h1
`define DVMC_RST_WAIT       20'h00000
`define DVMC_MAX_CURSRC     32'h3
`define DVMC_MIN_RESOL      32'h3
`define DVMC_MAX_RESOL      32'h5
`define DVMC_MIN_FORMAT     32'h1
`define DVMC_MAX_FORMAT     32'h3
`define DVMC_MIN_RDGCNT     32'h1
`define DVMC_MAX_RDGCNT     32'd999
`define DVMC_MIN_RANGE      32'h1
`define DVMC_MAX_RANGE      32'h5
`define DVMC_MAX_STORAGE    32'h2
`define DVMC_MIN_TRIGMODE   32'h1
`define DVMC_MAX_TRIGMODE   32'h4
`define DVMC_MAX_WAIT       32'd999999
// --------
// Timing figures
// --------
`define DVMC_DONE_PULSE_NS  500
`define DVMC_WAIT_TICK_US   100
`define DVMC_PLC100_R3      1
`define DVMC_PLC100_R4      10
`define DVMC_PLC100_R5      100
`define DVMC_RATE_AZON_R3   150
`define DVMC_RATE_AZON_R4   100
`define DVMC_RATE_AZON_R5   25
`define DVMC_RATE_AZOFF_R3  300
`define DVMC_RATE_AZOFF_R4  200
`define DVMC_RATE_AZOFF_R5  50
`define DVMC_LINE_HZ_60     60
`define DVMC_LINE_HZ_50     50
`endif

//--- core/dvmc_pkg.sv
// Types shared by the voltmeter measurement control block.
// Assumes the constant header is on the include path.
`default_nettype none
package dvmc_pkg;
    // Sequencer states of one measurement burst.
    typedef enum logic [2:0] {
        ST_IDLE, ST_ZERO_GO, ST_ZERO_WAIT, ST_IN_GO, ST_IN_WAIT, ST_GAP
    } dvmc_state_t;
    // Programmed configuration, one field per command.
    typedef struct packed {
        logic        autozero;
        logic [1:0]  curSrc;
        logic [2:0]  resol;
        logic [1:0]  format;
        logic [9:0]  rdgCnt;
        logic [2:0]  range;
        logic [1:0]  storage;
        logic [2:0]  trigMode;
        logic [19:0] waitTime;
    } dvmc_cfg_t;
endpackage
`default_nettype wire

//--- test/dvmc_checker.sv
// Port checker of the voltmeter measurement control.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module dvmc_checker #(
    parameter int CLK_HZ = 10_000_000 // Clock rate in hertz.
) (
    input wire logic ref_clk, rst, wb_cyc_i, wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic panelReset, busDeviceClear, lineIs50Hz,
    input wire logic convStart, convZeroPhase, convDone,
    input wire logic [23:0] convIntegCycles,
    input wire dvmc_pkg::dvmc_cfg_t cfgOut,
    input wire logic [2:0] digitCount,
    input wire logic leadDigitLimited, measurement_done_output
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic sawZ_reg;  // A zero start came since the last input start.
    logic needZ_reg; // A fresh zero is allowed without autozero.
    // Clear or a range or autozero change lets the stored zero go.
    always_ff @(posedge ref_clk) begin
        if (rst || convStart)
            sawZ_reg <= !rst && convZeroPhase;
        if (rst || panelReset || busDeviceClear || $changed(cfgOut.range)
            || $changed(cfgOut.autozero) || (wb_cyc_i && wb_we_i
            && wb_adr_i == 8'h30))
            needZ_reg <= 1'b1;
        else if (convStart && convZeroPhase)
            needZ_reg <= 1'b0;
    end
    AST_DEF: assert property (disable iff (1'b0) $fell(rst) |->
        cfgOut == {1'h1, 2'h0, 3'h5, 2'h1, 10'h001, 3'h5, 2'h0, 3'h1,
        20'h0}) else $error("config not at power-on values");
    AST_DIG: assert property ($stable(cfgOut.resol) |->
        digitCount == cfgOut.resol + 3'h1) else $error("bad digit count");
    AST_LEAD: assert property ($stable(cfgOut.resol) |->
        leadDigitLimited == (cfgOut.resol == 3'h3)) else $error("bad lead");
    AST_INT: assert property (!lineIs50Hz && $stable(cfgOut.resol) |->
        convIntegCycles == 24'(CLK_HZ / 100 * (cfgOut.resol == 3'h3 ? 1 :
        cfgOut.resol == 3'h4 ? 10 : 100) / 60)) else $error("bad integration");
    AST_ZIN: assert property (convDone && convZeroPhase |=>
        convStart && !convZeroPhase) else $error("no input after zero");
    AST_AZ: assert property (convStart && !convZeroPhase &&
        cfgOut.autozero |-> sawZ_reg) else $error("input without zero");
    AST_NOAZ: assert property (convStart && convZeroPhase &&
        !cfgOut.autozero |-> needZ_reg || $changed(cfgOut.range)
        || $changed(cfgOut.autozero)) else $error("needless zero");
    AST_DONE: assert property (convDone && !convZeroPhase |=>
        measurement_done_output ##1 !measurement_done_output)
        else $error("bad done pulse");
endmodule
bind dvmc_measurement_control dvmc_checker #(.CLK_HZ(CLK_HZ))
    u_dvmc_checker (.*);
`default_nettype wire

//--- test/dvmc_conv_model.sv
// Converter stand-in: answers each start after lat clocks.
// Assumes one start at a time; abort drops a running conversion.
`default_nettype none
module dvmc_conv_model (
    input wire logic ref_clk, rst, abort, convStart, convZeroPhase,
    input wire logic [23:0] zeroVal, inVal,
    input wire logic [7:0] lat,
    output logic convDone,
    output logic [23:0] convData
);
    logic [7:0] cnt_reg; // Clocks left in the running conversion.
    logic zph_reg;       // The running conversion measures zero.
    // Data is only valid with done; otherwise it keeps toggling.
    always_ff @(posedge ref_clk) begin
        convDone <= cnt_reg == 8'h01 && !abort && !rst;
        convData <= cnt_reg == 8'h01 ? (zph_reg ? zeroVal : inVal)
            : ~convData;
        if (rst || abort)
            cnt_reg <= 8'h00;
        else if (convStart)
            {cnt_reg, zph_reg} <= {lat, convZeroPhase};
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
    end
endmodule
`default_nettype wire

//--- test/dvmc_measurement_control_tb.sv
// Bench of the voltmeter control: registers, pins and readings.
// Assumes the converter model and the bound checker are compiled.
`default_nettype none
module dvmc_measurement_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 0, rst = 1, cyc = 0, we = 0, pnl = 0, dcl = 0, pd = 0;
    logic ack, cs, zp, cd, done;
    logic [7:0] adr = 8'h00, lat = 8'h01;
    logic [23:0] zv = 0, iv = 0, cdat, ez;
    logic [31:0] dat = 0, datO, q, v;
    int nErrors = 0, checked = 0, lo[9], hi[9], df[9];
    dvmc_measurement_control #(.CLK_HZ(60000)) u_dvmc_measurement_control (
        .ref_clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .panelReset(pnl), .busDeviceClear(dcl),
        .extTrigger(1'b0), .lineIs50Hz(1'b0), .convStart(cs),
        .convZeroPhase(zp), .convIntegCycles(), .convDone(cd),
        .convData(cdat), .cfgOut(), .digitCount(), .leadDigitLimited(),
        .measurement_done_output(done));
    dvmc_conv_model u_dvmc_conv_model (.ref_clk, .rst,
        .abort(pnl | dcl | (cyc & we & adr == 8'h30)),
        .convStart(cs), .convZeroPhase(zp), .zeroVal(zv), .inVal(iv),
        .lat, .convDone(cd), .convData(cdat));
    initial forever #50 ref_clk = ~ref_clk;
    initial begin
        repeat (20000) @(posedge ref_clk);
        nErrors++;
        giveVerdict();
    end
    function automatic logic [31:0] expRes(logic [23:0] d);
        return {{8{d[23]}}, d};
    endfunction
    task automatic chk(input logic [31:0] e, s, input string nm);
        checked++;
        if (s !== e) begin
            nErrors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One classic cycle; ack and read data are looked at once settled.
    task automatic wb(input logic w, input logic [7:0] a, input int d);
        int n;
        n = 0;
        @(posedge ref_clk);
        {cyc, we, adr, dat} <= {1'b1, w, a, 32'(d)};
        do begin
            @(negedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) nErrors++;
        q = datO;
        @(posedge ref_clk);
        cyc <= 1'b0;
    endtask
    task automatic waitDone(int k);
        for (int n = 0; k > 0 && n < 5000; n++) begin
            @(negedge ref_clk);
            if (done === 1'b1 && pd !== 1'b1) k--;
            pd = done;
        end
    endtask
    task automatic giveVerdict();
        $display("comparisons %0d errors %0d", checked, nErrors);
        if (nErrors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        lo = '{0, 0, 3, 1, 1, 1, 0, 1, 0};
        hi = '{1, 3, 5, 3, 999, 5, 2, 4, 999999};
        df = '{1, 0, 5, 1, 1, 5, 0, 1, 0};
        void'($urandom(26834));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        wb(1, 8'h3C, 5);
        wb(0, 8'h3C, 0);
        chk(0, q, "unmapped");
        for (int i = 0; i < 9; i++) begin
            wb(0, 8'(4 * i), 0);
            chk(df[i], q, "default");
            for (int j = 0; j < 3; j++) begin
                v = j == 0 ? lo[i] : j == 1 ? hi[i]
                    : lo[i] + $urandom % (hi[i] - lo[i] + 1);
                wb(1, 8'(4 * i), v);
                wb(1, 8'(4 * i), j == 0 ? lo[i] - 1 : hi[i] + 1);
                wb(0, 8'(4 * i), 0);
                chk(v, q, "setting");
            end
        end
        for (int i = 0; i < 3; i++) begin
            wb(1, 8'h04, 3);
            if (i == 2) wb(1, 8'h30, 0);
            {pnl, dcl} <= 2'b01 << i;
            repeat (6) @(posedge ref_clk);
            {pnl, dcl} <= 2'b00;
            wb(0, 8'h04, 0);
            chk(0, q, "restored");
        end
        wb(1, 8'h1C, 4);
        repeat (3000) @(posedge ref_clk);
        wb(1, 8'h08, 3);
        wb(1, 8'h10, 2);
        wb(1, 8'h18, 1);
        wb(1, 8'h1C, 3);
        for (int k = 0; k < 3; k++) begin
            if (k == 1) wb(1, 8'h00, 0);
            v = $urandom;
            if (k < 2) ez = v[23:0];
            {zv, iv, lat} <= {v[23:0], 24'($urandom), 8'($urandom_range(40, 1))};
            wb(1, 8'h2C, 1);
            waitDone(2);
            wb(0, 8'h28, 0);
            chk(expRes(iv - ez), q, "reading");
        end
        wb(0, 8'h38, 0);
        chk(6, q, "stored");
        giveVerdict();
    end
endmodule
`default_nettype wire
